// File: common/prf_pkg.sv
// constants shared by the panel refresh unit and its fifo
// assumes one 40 MHz ref_clk and a byte-wide register port
// What this block does
// - start raises bus request, fetch after grant
// - send exactly one panel of bytes
// - shift clock strobes each sent beat
// - drop bus request once frame sent
// - one frame pulse per frame period
// - polarity output toggles every frame
// - frame rate is source over D times setting
// - D chosen from common count table
// - line pulse period is D source periods
// - larger setting lengthens frame period
// - setting bit 8 lives in control bit 1
// - width code 00 selects byte transfers
// - width code 01 selects nibble transfers
// - source clock is slow oscillator or timer3
package prf_pkg;
   // register offsets on the plain port
   localparam logic [11:0] PRF_OFS_CTL     = 12'h363; // lcd_control
   localparam logic [11:0] PRF_OFS_FRAME   = 12'h364; // frame_setting_low
   localparam logic [11:0] PRF_OFS_SA_LO   = 12'h368; // source start address low
   localparam logic [11:0] PRF_OFS_SA_HI   = 12'h369; // source start address high
   localparam logic [11:0] PRF_OFS_LINE    = 12'h36a; // bytes per line
   localparam logic [11:0] PRF_OFS_CFG     = 12'h36b; // common code, clock select
   localparam logic [11:0] PRF_OFS_STAT    = 12'h36c; // read-only status
   // control field positions
   localparam int PRF_CTL_ON    = 7;
   localparam int PRF_CTL_WIDTH_SEL_HI  = 4;
   localparam int PRF_CTL_WIDTH_SEL_LO  = 3;
   localparam int PRF_CTL_TYPE  = 2;
   localparam int PRF_CTL_FP8   = 1;
   localparam int PRF_CTL_START = 0;
   localparam int PRF_CFG_CLKSEL = 4;
   localparam logic [7:0] PRF_RST_BYTE = 8'h00;
   localparam logic [7:0] PRF_CTL_WMASK = 8'h9f; // bits 6:5 read zero
   localparam logic [7:0] PRF_CFG_WMASK = 8'h1f;
   localparam logic [1:0] PRF_BUS_BYTE   = 2'b00;
   localparam logic [1:0] PRF_BUS_NIBBLE = 2'b01;
   localparam int PRF_FIFO_W = 8;
   localparam int PRF_FIFO_D = 16;
   // slow oscillator figure, one source count per half period counted
   localparam int PRF_SLOW_HZ = 32768;
   typedef enum logic [3:0] {
      PRF_ST_IDLE  = 4'b0001,
      PRF_ST_REQ   = 4'b0010,
      PRF_ST_FETCH = 4'b0100,
      PRF_ST_DRAIN = 4'b1000
   } prf_state_t;
   // line period in half source periods (2*D) per common code
   function automatic logic [3:0] prf_d_halves(input logic [3:0] code);
      case (code)
         4'h0:    prf_d_halves = 4'hd; // 64 commons, 6.5
         4'h1:    prf_d_halves = 4'hc; // 68, 6
         4'h2:    prf_d_halves = 4'ha; // 80, 5
         4'h3:    prf_d_halves = 4'h8; // 100, 4
         4'h4:    prf_d_halves = 4'h7; // 120, 3.5
         4'h5:    prf_d_halves = 4'h6; // 128, 3
         4'h6:    prf_d_halves = 4'h5; // 144, 2.5
         4'h7:    prf_d_halves = 4'h5; // 160, 2.5
         4'h8:    prf_d_halves = 4'h4; // 200, 2
         default: prf_d_halves = 4'h3; // 240, 1.5
      endcase
   endfunction
   // number of commons per code
   function automatic logic [8:0] prf_commons(input logic [3:0] code);
      case (code)
         4'h0:    prf_commons = 9'd64;
         4'h1:    prf_commons = 9'd68;
         4'h2:    prf_commons = 9'd80;
         4'h3:    prf_commons = 9'd100;
         4'h4:    prf_commons = 9'd120;
         4'h5:    prf_commons = 9'd128;
         4'h6:    prf_commons = 9'd144;
         4'h7:    prf_commons = 9'd160;
         4'h8:    prf_commons = 9'd200;
         default: prf_commons = 9'd240;
      endcase
   endfunction
endpackage

// File: hdl/prf_panel_refresh_unit.sv
// shift-register panel refresh unit with its data fifo
// assumes bus grant and memory data come from logic on ref_clk
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

// fifo of flip-flops, first word shown on out_data
module prf_fifo
   import prf_pkg::*;
#(
   parameter int W = PRF_FIFO_W,
   parameter int D = PRF_FIFO_D
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem_q [D];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          push;
   logic          pop;

   // honest full and empty flags
   assign in_ready  = (cnt_q != (AW+1)'(D));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rp_q];
   assign push      = ce && in_valid && in_ready;
   assign pop       = ce && out_valid && out_ready;

   // storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   // pointers and fill count
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + AW'(1);
         if (pop) rp_q <= rp_q + AW'(1);
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // prf_fifo

module prf_panel_refresh_unit
   import prf_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic [11:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             bus_req,
   input  wire logic        bus_grant,
   output logic [15:0]      mem_addr,
   output logic             mem_rd,
   input  wire logic [7:0]  mem_rdata,
   input  wire logic        slow_clock_pin,
   input  wire logic        timer3_output,
   output logic [7:0]       lcd_data,
   output logic             shift_clock_strobe,
   output logic             line_pulse_output,
   output logic             frame_pulse_output,
   output logic             polarity_toggle_output,
   output logic             display_off_output_n
);
   logic [7:0]  ctl_q, frame_lo_q, sa_lo_q, sa_hi_q;
   logic [7:0]  line_bytes_q, cfg_q, rdata_q;
   logic [1:0]  lf_sync_q, t3_sync_q;
   logic        src_prev_q, src_now, src_edge;
   logic [3:0]  hcnt_q, d_halves;
   logic [8:0]  line_cnt_q, frame_set;
   logic        line_wrap, frame_wrap;
   logic        line_q, frame_q, pol_q, frame_go_q;
   prf_state_t  st_q;
   logic        req_q, rd_q, pend_q;
   logic [15:0] addr_q, total, fetched_q, sent_q;
   logic        fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0]  fifo_out_data, hold_q, data_q;
   logic [1:0]  ph_q;
   logic        half_q, sclk_q, nibble, done;

   // 9-bit frame setting from low register and control bit 1
   assign frame_set = {ctl_q[PRF_CTL_FP8], frame_lo_q};
   assign d_halves  = prf_d_halves(cfg_q[3:0]);
   assign total     = 16'(line_bytes_q) * 16'(prf_commons(cfg_q[3:0]));
   assign nibble    = (ctl_q[PRF_CTL_WIDTH_SEL_HI:PRF_CTL_WIDTH_SEL_LO] == PRF_BUS_NIBBLE);

   // register writes
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_q        <= PRF_RST_BYTE;
         frame_lo_q   <= PRF_RST_BYTE;
         sa_lo_q      <= PRF_RST_BYTE;
         sa_hi_q      <= PRF_RST_BYTE;
         line_bytes_q <= PRF_RST_BYTE;
         cfg_q        <= PRF_RST_BYTE;
      end else if (ce && reg_wr) begin
         case (reg_addr)
            PRF_OFS_CTL:   ctl_q <= reg_wdata & PRF_CTL_WMASK;
            PRF_OFS_FRAME: frame_lo_q <= reg_wdata;
            PRF_OFS_SA_LO: sa_lo_q <= reg_wdata;
            PRF_OFS_SA_HI: sa_hi_q <= reg_wdata;
            PRF_OFS_LINE:  line_bytes_q <= reg_wdata;
            PRF_OFS_CFG:   cfg_q <= reg_wdata & PRF_CFG_WMASK;
            default:       ;
         endcase
      end
   end

   // read data for exactly the cycle after the strobe, zero otherwise
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= PRF_RST_BYTE;
      end else if (ce) begin
         if (reg_rd) begin
            case (reg_addr)
               PRF_OFS_CTL:   rdata_q <= ctl_q;
               PRF_OFS_FRAME: rdata_q <= frame_lo_q;
               PRF_OFS_SA_LO: rdata_q <= sa_lo_q;
               PRF_OFS_SA_HI: rdata_q <= sa_hi_q;
               PRF_OFS_LINE:  rdata_q <= line_bytes_q;
               PRF_OFS_CFG:   rdata_q <= cfg_q;
               PRF_OFS_STAT:  rdata_q <= {4'h0, st_q};
               default:       rdata_q <= PRF_RST_BYTE;
            endcase
         end else begin
            rdata_q <= PRF_RST_BYTE;
         end
      end
   end

   // source clock pins pass two flops before use
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         lf_sync_q  <= 2'b00;
         t3_sync_q  <= 2'b00;
         src_prev_q <= 1'b0;
      end else if (ce) begin
         lf_sync_q  <= {lf_sync_q[0], slow_clock_pin};
         t3_sync_q  <= {t3_sync_q[0], timer3_output};
         src_prev_q <= src_now;
      end
   end

   // both edges counted so half counts of D are exact
   assign src_now  = cfg_q[PRF_CFG_CLKSEL] ? t3_sync_q[1] : lf_sync_q[1];
   assign src_edge = ce && (src_now != src_prev_q);
   assign line_wrap  = src_edge && (hcnt_q >= d_halves - 4'h1);
   assign frame_wrap = line_wrap && (line_cnt_q >= frame_set - 9'h001);

   // line and frame counters with their pulse outputs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hcnt_q     <= 4'h0;
         line_cnt_q <= 9'h000;
         line_q     <= 1'b0;
         frame_q    <= 1'b0;
         pol_q      <= 1'b0;
      end else if (src_edge) begin
         hcnt_q <= line_wrap ? 4'h0 : hcnt_q + 4'h1;
         line_q <= line_wrap;                          // high first half count
         if (line_wrap) begin
            line_cnt_q <= frame_wrap ? 9'h000 : line_cnt_q + 9'h001;
            frame_q    <= frame_wrap;                   // high for line 0
            if (frame_wrap) pol_q <= ~pol_q;
         end
      end
   end

   // frame request flag: set wins over the clear by the fetch engine
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         frame_go_q <= 1'b0;
      end else if (ce) begin
         if (frame_wrap && ctl_q[PRF_CTL_START]) begin
            frame_go_q <= 1'b1;
         end else if (!ctl_q[PRF_CTL_START] || st_q == PRF_ST_REQ) begin
            frame_go_q <= 1'b0;
         end
      end
   end

   assign done = (sent_q == total) && (ph_q == 2'd0) && !half_q;

   // fetch engine: request bus, read one panel, release bus
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q      <= PRF_ST_IDLE;
         req_q     <= 1'b0;
         rd_q      <= 1'b0;
         pend_q    <= 1'b0;
         addr_q    <= 16'h0000;
         fetched_q <= 16'h0000;
      end else if (ce) begin
         pend_q <= rd_q;
         rd_q   <= 1'b0;
         case (st_q)
            PRF_ST_IDLE: begin
               if (frame_go_q && ctl_q[PRF_CTL_START]) begin
                  st_q      <= PRF_ST_REQ;
                  req_q     <= 1'b1;
                  addr_q    <= {sa_hi_q, sa_lo_q};
                  fetched_q <= 16'h0000;
               end
            end
            PRF_ST_REQ: begin
               if (bus_grant) st_q <= PRF_ST_FETCH;
            end
            PRF_ST_FETCH: begin
               if (fetched_q == total) begin
                  st_q <= PRF_ST_DRAIN;
               end else if (fifo_in_ready && !rd_q && !pend_q) begin
                  rd_q      <= 1'b1;
                  addr_q    <= (fetched_q == 16'h0000) ? addr_q : addr_q + 16'h0001;
                  fetched_q <= fetched_q + 16'h0001;
               end
            end
            PRF_ST_DRAIN: begin
               if (done && !pend_q) begin
                  st_q  <= PRF_ST_IDLE;
                  req_q <= 1'b0;
               end
            end
            default: begin
               st_q  <= PRF_ST_IDLE;
               req_q <= 1'b0;
            end
         endcase
      end
   end

   prf_fifo #(
      .W (PRF_FIFO_W),
      .D (PRF_FIFO_D)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .in_valid  (pend_q),
      .in_ready  (fifo_in_ready),
      .in_data   (mem_rdata),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   // a byte leaves the fifo when a new byte or high nibble is loaded
   assign fifo_pop = (ph_q == 2'd0) && !half_q && (sent_q != total);

   // sender: load data, raise shift clock, drop shift clock
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_q   <= 2'd0;
         half_q <= 1'b0;
         hold_q <= 8'h00;
         data_q <= 8'h00;
         sclk_q <= 1'b0;
         sent_q <= 16'h0000;
      end else if (ce) begin
         if (st_q == PRF_ST_IDLE) sent_q <= 16'h0000;
         case (ph_q)
            2'd0: begin
               if (half_q) begin
                  data_q <= {4'h0, hold_q[3:0]};             // low nibble
                  half_q <= 1'b0;
                  ph_q   <= 2'd1;
               end else if (fifo_pop && fifo_out_valid) begin
                  sent_q <= sent_q + 16'h0001;
                  ph_q   <= 2'd1;
                  if (nibble) begin
                     data_q <= {4'h0, fifo_out_data[7:4]};
                     hold_q <= fifo_out_data;
                     half_q <= 1'b1;
                  end else begin
                     data_q <= fifo_out_data;
                  end
               end
            end
            2'd1: begin
               sclk_q <= 1'b1;
               ph_q   <= 2'd2;
            end
            default: begin
               sclk_q <= 1'b0;
               ph_q   <= 2'd0;
            end
         endcase
      end
   end

   assign reg_rdata              = rdata_q;
   assign bus_req                = req_q;
   assign mem_addr               = addr_q;
   assign mem_rd                 = rd_q;
   assign lcd_data               = data_q;
   assign shift_clock_strobe     = sclk_q;
   assign line_pulse_output      = line_q;
   assign frame_pulse_output     = frame_q;
   assign polarity_toggle_output = pol_q;
   assign display_off_output_n   = ctl_q[PRF_CTL_ON];

   // checks
   sequence s_sclk_beat;
      sclk_q ##1 !sclk_q;
   endsequence

   a_fetch_after_grant: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      rd_q |-> req_q && (st_q == PRF_ST_FETCH))
      else $error("memory read without bus grant");

   a_req_on_start: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      (st_q == PRF_ST_IDLE && frame_go_q && ctl_q[PRF_CTL_START]) |=> req_q)
      else $error("bus request not raised");

   a_count_bound: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      (sent_q <= total) && (fetched_q <= total))
      else $error("more bytes than one panel");

   a_sclk_shape: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      $rose(sclk_q) |-> $past(ph_q) == 2'd1 ##0 s_sclk_beat)
      else $error("shift clock beat malformed");

   a_req_release: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      (st_q == PRF_ST_DRAIN && done && !pend_q) |=> !req_q && st_q == PRF_ST_IDLE)
      else $error("bus request held after frame");

   a_frame_pol: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      $rose(frame_q) |-> pol_q != $past(pol_q))
      else $error("polarity did not toggle at frame");

   a_frame_line0: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      $rose(frame_q) |-> line_cnt_q == 9'h000 && hcnt_q == 4'h0)
      else $error("frame pulse off line zero");

   a_line_phase: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      $rose(line_q) |-> hcnt_q == 4'h0)
      else $error("line pulse out of phase");

   a_display_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !ctl_q[PRF_CTL_ON] |-> !display_off_output_n)
      else $error("display not held off");

   a_stop_holds: assert property (@(posedge ref_clk) disable iff (!reset_n || !ce)
      (st_q == PRF_ST_IDLE && !ctl_q[PRF_CTL_START]) |=> st_q == PRF_ST_IDLE)
      else $error("frame began while stopped");
endmodule // prf_panel_refresh_unit

// File: tb/prf_lcd_driver_model.sv
// behavioural shift-register panel driver on the data side
// assumes beats are marked by one-cycle shift strobes on ref_clk
`timescale 1ns/1ps

module prf_lcd_driver_model (
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire logic       frame_active,
   input  wire logic       nibble_mode,
   input  wire logic [7:0] lcd_data,
   input  wire logic       shift_clock_strobe,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            upper_dirty
);
   logic       phase_q;
   logic [3:0] hi_q;

   // latch data on each strobe, rebuild bytes from nibble pairs
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_valid    <= 1'b0;
         rx_data     <= 8'h00;
         upper_dirty <= 1'b0;
         phase_q     <= 1'b0;
         hi_q        <= 4'h0;
      end else begin
         rx_valid <= 1'b0;
         if (!frame_active) begin
            phase_q <= 1'b0;
         end else if (shift_clock_strobe) begin
            if (!nibble_mode) begin
               rx_valid <= 1'b1;
               rx_data  <= lcd_data;
            end else if (!phase_q) begin
               hi_q    <= lcd_data[3:0];
               phase_q <= 1'b1;
            end else begin
               rx_valid <= 1'b1;
               rx_data  <= {hi_q, lcd_data[3:0]};
               phase_q  <= 1'b0;
            end
            if (nibble_mode && lcd_data[7:4] != 4'h0) upper_dirty <= 1'b1; // upper lines idle
         end
      end
   end
endmodule // prf_lcd_driver_model

// File: tb/prf_panel_refresh_unit_bench.sv
// self-checking bench for the panel refresh unit
// assumes timer3 toggles every 4 cycles and a free 32.768 kHz pin
`timescale 1ns/1ps

module prf_panel_refresh_unit_bench;
   import prf_pkg::*;
   logic ref_clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, bus_grant = 0;
   logic slow_clock_pin = 0, timer3_output = 0, nibble_mode = 0, ce = 1;
   logic [11:0] reg_addr = 12'h000;
   logic [7:0]  reg_wdata = 8'h00, mem_rdata = 8'h00, reg_rdata, lcd_data, rx_data, key;
   logic [15:0] mem_addr, sa;
   logic bus_req, mem_rd, shift_clock_strobe, line_pulse_output, frame_pulse_output;
   logic polarity_toggle_output, display_off_output_n, rx_valid, upper_dirty, rd_seen = 0;
   logic [7:0]  exp_rd[$];
   logic [7:0]  exp_px[$];
   int mismatches = 0, comparisons = 0, gcnt = 0, gwait, n, i;
   logic p0, p1;
   int halves[10] = '{13, 12, 10, 8, 7, 6, 5, 5, 4, 3};

   always #12.5 ref_clk = ~ref_clk;
   always #15259 slow_clock_pin = ~slow_clock_pin;
   // timer source: one half period is 4 clocks
   always begin
      repeat (4) @(posedge ref_clk);
      timer3_output <= ~timer3_output;
   end

   prf_panel_refresh_unit dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .bus_req(bus_req), .bus_grant(bus_grant),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
      .slow_clock_pin(slow_clock_pin), .timer3_output(timer3_output), .lcd_data(lcd_data),
      .shift_clock_strobe(shift_clock_strobe), .line_pulse_output(line_pulse_output),
      .frame_pulse_output(frame_pulse_output),
      .polarity_toggle_output(polarity_toggle_output),
      .display_off_output_n(display_off_output_n));

   prf_lcd_driver_model drv_u (.ref_clk(ref_clk), .reset_n(reset_n), .frame_active(bus_req),
      .nibble_mode(nibble_mode), .lcd_data(lcd_data), .shift_clock_strobe(shift_clock_strobe),
      .rx_valid(rx_valid), .rx_data(rx_data), .upper_dirty(upper_dirty));

   function automatic logic [7:0] mem_val(input logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ key;
   endfunction

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // memory answers one cycle after a read, scrambles otherwise; grant after a delay
   always @(posedge ref_clk) begin
      mem_rdata <= mem_rd ? mem_val(mem_addr) : ~mem_rdata;
      gcnt      <= bus_req ? gcnt + 1 : 0;
      bus_grant <= bus_req && gcnt >= gwait;
   end

   // result watcher: register reads and received panel bytes
   always @(posedge ref_clk) begin
      rd_seen <= reg_rd;
      if (rd_seen) check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_rd.pop_front()});
      if (mem_rd) check("grant_before_fetch", bus_grant, 1'b1);
      if (rx_valid) begin
         if (exp_px.size() == 0) check("lcd_extra_byte", 1'b1, 1'b0);
         else check("lcd_byte", rx_data, exp_px.pop_front());
      end
   end

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_rd.push_back(d);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   // cycles between the 2nd and 3rd rise of line (sel 0) or frame (sel 1) pulse
   task automatic period(input bit sel, output int cyc, output logic pa, output logic pb);
      int c, e, t0;
      logic v, pv;
      e = 0; t0 = 0; pv = 1'b1; cyc = 0;
      for (c = 0; c < 20000 && e < 3; c++) begin
         @(posedge ref_clk);
         v = sel ? frame_pulse_output : line_pulse_output;
         if (v && !pv) begin
            e++;
            if (e == 2) begin t0 = c; pa = polarity_toggle_output; end
            if (e == 3) begin cyc = c - t0; pb = polarity_toggle_output; end
         end
         pv = v;
      end
   endtask

   task automatic wait_req(input logic lvl, input int lim);
      int k;
      for (k = 0; k < lim && bus_req !== lvl; k++) @(posedge ref_clk);
      check("bus_req", bus_req, lvl);
   endtask

   initial begin
      #(90000 * 25);
      mismatches++;
      summarize();
   end

   initial begin
      void'($urandom(32'hef75));
      key   = 8'($urandom);
      gwait = $urandom % 8;
      sa    = 16'($urandom) & 16'h7f00;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      // reset values, masked bits, unmapped place
      rd(PRF_OFS_CTL, 8'h00);
      rd(PRF_OFS_FRAME, 8'h00);
      rd(PRF_OFS_STAT, 8'h01);
      wr(PRF_OFS_CTL, 8'h7e);
      rd(PRF_OFS_CTL, 8'h1e);
      wr(12'h365, 8'haa);
      rd(12'h365, 8'h00);
      check("display_off", display_off_output_n, 1'b0);
      // frame setting 300 = {1, 0x2c}; 240 commons from timer source
      wr(PRF_OFS_FRAME, 8'h2c); // between commons and 320
      rd(PRF_OFS_FRAME, 8'h2c);
      wr(PRF_OFS_CTL, 8'h82);
      wr(PRF_OFS_CFG, 8'h19);
      wr(PRF_OFS_LINE, 8'h01);
      // clock enable low: a write must be frozen out
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(PRF_OFS_LINE, 8'h55);
      ce <= 1'b1;
      rd(PRF_OFS_LINE, 8'h01);
      wr(PRF_OFS_SA_LO, sa[7:0]);
      wr(PRF_OFS_SA_HI, sa[15:8]);
      repeat (3) @(posedge ref_clk);
      check("display_off", display_off_output_n, 1'b1);
      period(1'b1, n, p0, p1);
      check("frame_period", 16'(n), 16'd3600);
      check("polarity_flip", p0 ^ p1, 1'b1);
      for (i = 0; i < 10; i++) begin
         wr(PRF_OFS_CFG, 8'h10 | 8'(i));
         period(1'b0, n, p0, p1);
         check("line_period", 16'(n), 16'(halves[i] * 4));
      end
      wr(PRF_OFS_CFG, 8'h09);
      period(1'b0, n, p0, p1);
      check("slow_line_period", n >= 1830 && n <= 1832, 1'b1);
      wr(PRF_OFS_CFG, 8'h19);
      // one whole frame per width code 00, 01 and 10, reserved code 10 behaves as bytes
      for (i = 0; i < 3; i++) begin
         nibble_mode = (i == 1);
         for (n = 0; n < 240; n++) exp_px.push_back(mem_val(sa + 16'(n)));
         wr(PRF_OFS_CTL, 8'h82 | 8'(i << 3)); // width set before start
         wr(PRF_OFS_CTL, 8'h83 | 8'(i << 3));
         wait_req(1'b1, 8000);
         wait_req(1'b0, 3000);
         wr(PRF_OFS_CTL, 8'h82 | 8'(i << 3));
         repeat (5) @(posedge ref_clk);
         check("frame_bytes_left", 16'(exp_px.size()), 16'd0);
      end
      // stopped: no request over two frame periods
      n = 0;
      repeat (7300) begin
         @(posedge ref_clk);
         if (bus_req !== 1'b0) n++;
      end
      check("stopped_requests", 16'(n), 16'd0);
      check("nibble_upper_lines", upper_dirty, 1'b0);
      summarize();
   end
endmodule // prf_panel_refresh_unit_bench
